// ===== core/svs_stage.sv
// one sequence voltage stage: block check, under-block, trip timing, registers
// What this block does
// [RL1] under mode: trip suppressed while voltage below under-block level
// [RL2] under-block held until all line voltages exceed pick-up level
// [RL3] under-block level zero disables under-block entirely
// [RL4] blocking input sampled once at start of each processing cycle
// [RL5] pick-up without blocking asserts start and starts operating timer
// [RL6] pick-up with blocking asserts blocked, no start or trip
// [RL7] blocking during start clears start and runs release handling
// [RL8] blocking emits event with start voltage, fault type, display pulse
// [RL9] outside source asserts blocking 5 ms before delay expires
// [RL10] stage forcing lets a software switch drive blocking
// [RL11] instant operation trips in the same cycle as start
// [RL12] fixed delay trips after set delay while pick-up holds
// [RL13] inverse delay computed from dial, multiplier, setting, voltage
// [RL14] delay type: 1 fixed, 2 inverse, fixed by default
// [RL15] fixed delay in 5 ms steps, default 40 ms, zero is instant
// [RL16] expected operating time reported, recomputed live in inverse mode
// [RL17] signed remaining time to trip exposed while counting
// [RL18] ratio of measured voltage to setting in hundredths
// [RL19] primary pick-up voltage in 0.1 V from setting and scaling
// [RL20] logical node behaviour reported as on/blocked/test/test-blocked/off
// [RL21] pick-up releases at 97 percent over, 103 percent under
// [RL22] release delay, default 60 ms, holds start after pick-up drops
// [RL23] timer advances once per cycle, trip decided after block check
`timescale 1ns/1ns
`include "svs_cfg.svh"
module svs_stage #(
    parameter int TICK_CYC = `SVS_TICK_CYC
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rstn,
    // avalon-mm slave
    input  wire logic [7:0]          address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    output logic [31:0]              readdata,
    output logic                     waitrequest,
    // measurement and blocking
    input  wire logic [15:0]         measured_voltage,
    input  wire logic [15:0]         min_line_voltage,
    input  wire logic                block_in,
    // stage outputs
    output svs_pkg::svs_out_s        stage_out,
    output svs_pkg::svs_evt_s        stage_evt,
    output logic                     cycle_tick
);
    import svs_pkg::*;

    // ----------------------------------------
    // processing cycle divider
    // ----------------------------------------
    logic [31:0] div_ff;
    logic [31:0] nxt_div;
    logic        tick;

    always_comb begin
        tick    = (div_ff == 32'(TICK_CYC - 1));
        nxt_div = tick ? 32'h0 : div_ff + 32'h1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_ff <= 32'h0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    assign cycle_tick = tick;

    // ----------------------------------------
    // blocking input synchroniser
    // ----------------------------------------
    logic blk_m_ff;
    logic blk_s_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blk_m_ff <= 1'b0;
            blk_s_ff <= 1'b0;
        end else begin
            blk_m_ff <= block_in;
            blk_s_ff <= blk_m_ff;
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    svs_ctrl_s   ctrl_ff,  nxt_ctrl;
    logic [15:0] uset_ff,  nxt_uset;
    logic [15:0] under_block_level_ff,  nxt_under_block_level;
    logic [18:0] delay_ff, nxt_delay;
    logic [15:0] tdial_ff, nxt_tdial;
    logic [15:0] mult_ff,  nxt_mult;
    logic [18:0] rel_ff,   nxt_rel;
    logic [23:0] vtpri_ff, nxt_vtpri;
    logic        ack_ff,   nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [31:0] rd_mux;
    logic        wr_go;

    // status values feeding reads
    logic [18:0] expect_t;
    logic [19:0] remain_t;
    logic [23:0] ratio_t;
    logic [31:0] prim_t;
    svs_out_s    out_ff;
    logic        under_block_level_act_ff;
    svs_ln_e     ln_beh;
    logic [15:0] evv_ff;
    logic        evu_ff;
    logic [7:0]  evcnt_ff;

    always_comb begin
        unique case (address)
            `SVS_OFS_CTRL:    rd_mux = {23'h0, ctrl_ff};
            `SVS_OFS_USET:    rd_mux = {16'h0, uset_ff};
            `SVS_OFS_UNDER_BLOCK_LEVEL:    rd_mux = {16'h0, under_block_level_ff};
            `SVS_OFS_DELAY:   rd_mux = {13'h0, delay_ff};
            `SVS_OFS_TDIAL:   rd_mux = {16'h0, tdial_ff};
            `SVS_OFS_MULT:    rd_mux = {16'h0, mult_ff};
            `SVS_OFS_RELEASE: rd_mux = {13'h0, rel_ff};
            `SVS_OFS_VTPRI:   rd_mux = {8'h0, vtpri_ff};
            `SVS_OFS_STATUS:  rd_mux = {25'h0, ln_beh, under_block_level_act_ff, out_ff};
            `SVS_OFS_EXPECT:  rd_mux = {13'h0, expect_t};      // [RL16]
            `SVS_OFS_REMAIN:  rd_mux = 32'(signed'(remain_t)); // [RL17]
            `SVS_OFS_RATIO:   rd_mux = {8'h0, ratio_t};        // [RL18]
            `SVS_OFS_PRIM:    rd_mux = prim_t;                 // [RL19]
            `SVS_OFS_BLKEVT:  rd_mux = {evcnt_ff, 7'h0, evu_ff, evv_ff};
            default:          rd_mux = 32'h0;
        endcase
    end

    // one wait cycle, then the request is answered at the next edge
    always_comb begin
        nxt_ack   = (read | write) & ~ack_ff;
        wr_go     = write & ack_ff;
        nxt_rdata = (read & ~ack_ff) ? rd_mux : rdata_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_uset  = uset_ff;
        nxt_under_block_level  = under_block_level_ff;
        nxt_delay = delay_ff;
        nxt_tdial = tdial_ff;
        nxt_mult  = mult_ff;
        nxt_rel   = rel_ff;
        nxt_vtpri = vtpri_ff;
        if (wr_go) begin
            unique case (address)
                `SVS_OFS_CTRL:    nxt_ctrl  = writedata[8:0];
                `SVS_OFS_USET:    nxt_uset  = writedata[15:0];
                `SVS_OFS_UNDER_BLOCK_LEVEL:    nxt_under_block_level  = writedata[15:0];
                `SVS_OFS_DELAY:   nxt_delay = writedata[18:0]; // [RL15]
                `SVS_OFS_TDIAL:   nxt_tdial = writedata[15:0];
                `SVS_OFS_MULT:    nxt_mult  = writedata[15:0];
                `SVS_OFS_RELEASE: nxt_rel   = writedata[18:0];
                `SVS_OFS_VTPRI:   nxt_vtpri = writedata[23:0];
                default:          nxt_ctrl  = ctrl_ff;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff  <= `SVS_RST_CTRL;  // [RL14]
            uset_ff  <= `SVS_RST_USET;
            under_block_level_ff  <= `SVS_RST_UNDER_BLOCK_LEVEL;
            delay_ff <= `SVS_RST_DELAY; // [RL15]
            tdial_ff <= `SVS_RST_TDIAL;
            mult_ff  <= `SVS_RST_MULT;
            rel_ff   <= `SVS_RST_RELEASE; // [RL22]
            vtpri_ff <= `SVS_RST_VTPRI;
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            uset_ff  <= nxt_uset;
            under_block_level_ff  <= nxt_under_block_level;
            delay_ff <= nxt_delay;
            tdial_ff <= nxt_tdial;
            mult_ff  <= nxt_mult;
            rel_ff   <= nxt_rel;
            vtpri_ff <= nxt_vtpri;
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign waitrequest = (read | write) & ~ack_ff;
    assign readdata    = rdata_ff;

    // ----------------------------------------
    // live values: ratio, primary level, expected time
    // ----------------------------------------
    logic [23:0] rdiff;
    logic [35:0] inv_num;
    logic [35:0] inv_t;
    logic        instant;

    always_comb begin
        ratio_t = (uset_ff == 16'h0) ? 24'h0
                : 24'((32'(measured_voltage) * 32'h64) / 32'(uset_ff)); // [RL18]
        prim_t  = 32'((40'(uset_ff) * 40'(vtpri_ff)) / 40'h3E8);      // [RL19]
        rdiff   = (ratio_t > 24'h64) ? ratio_t - 24'h64 : 24'h64 - ratio_t;
        // t = k * a / |Um/Us - 1|, k and a in hundredths, result in 5 ms cycles
        inv_num = 36'(tdial_ff) * 36'(mult_ff) * 36'h2;               // [RL13]
        inv_t   = (rdiff == 24'h0) ? 36'(`SVS_TIME_MAX_TICKS)
                : inv_num / 36'(rdiff);
        if (ctrl_ff.dly_type == SVS_DLY_INVERSE) begin
            expect_t = (inv_t > 36'(`SVS_TIME_MAX_TICKS)) ? `SVS_TIME_MAX_TICKS
                     : inv_t[18:0];                                   // [RL16]
        end else begin
            expect_t = delay_ff;                                      // [RL12]
        end
        instant = (expect_t == 19'h0);                                // [RL11]
    end

    // ----------------------------------------
    // pick-up comparator and under-block latch
    // ----------------------------------------
    logic        pick_ff, nxt_pick;
    logic        nxt_under_block_level_act;
    logic [23:0] meas_pct;
    logic [23:0] rel_lvl;
    logic        blk_ff, nxt_blk;
    logic        stage_off;

    always_comb begin
        stage_off = (ctrl_ff.ln_mode == SVS_LN_OFF);
        meas_pct  = 24'(measured_voltage) * 24'(`SVS_PCT_FULL);
        rel_lvl   = 24'(uset_ff) * (ctrl_ff.under_mode ? 24'(`SVS_REL_UNDER_PCT)
                                                      : 24'(`SVS_REL_OVER_PCT));
        nxt_pick  = pick_ff;
        nxt_under_block_level_act = under_block_level_act_ff;
        nxt_blk   = blk_ff;
        if (tick) begin
            nxt_blk = ctrl_ff.force_en ? ctrl_ff.force_blk : blk_s_ff; // [RL4] [RL10]
            if (ctrl_ff.under_mode) begin
                nxt_pick = pick_ff ? (meas_pct < rel_lvl)
                                   : (measured_voltage < uset_ff);     // [RL21]
            end else begin
                nxt_pick = pick_ff ? (meas_pct > rel_lvl)
                                   : (measured_voltage > uset_ff);     // [RL21]
            end
            if (!ctrl_ff.under_mode || under_block_level_ff == 16'h0) begin
                nxt_under_block_level_act = 1'b0;                                   // [RL3]
            end else if (measured_voltage < under_block_level_ff) begin
                nxt_under_block_level_act = 1'b1;                                   // [RL1]
            end else if (min_line_voltage > uset_ff) begin
                nxt_under_block_level_act = 1'b0;                                   // [RL2]
            end
        end
        if (stage_off) begin
            nxt_pick = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pick_ff     <= 1'b0;
            under_block_level_act_ff <= 1'b0;
            blk_ff      <= 1'b0;
        end else begin
            pick_ff     <= nxt_pick;
            under_block_level_act_ff <= nxt_under_block_level_act;
            blk_ff      <= nxt_blk;
        end
    end

    // ----------------------------------------
    // start, trip and release sequencing
    // ----------------------------------------
    svs_state_e  st_ff, nxt_st;
    logic [18:0] tmr_ff, nxt_tmr;
    logic [18:0] rcnt_ff, nxt_rcnt;
    svs_out_s    nxt_out;
    logic [18:0] tmr_inc;
    logic        trip_ok;

    // the comparator result and block sample of this tick arrive one clock later
    logic        eval_ff;

    always_comb begin
        nxt_st   = st_ff;
        nxt_tmr  = tmr_ff;
        nxt_rcnt = rcnt_ff;
        nxt_out  = out_ff;
        tmr_inc  = tmr_ff + 19'h1;
        trip_ok  = ~under_block_level_act_ff;                                       // [RL1]
        if (stage_off) begin
            nxt_st  = SVS_IDLE;
            nxt_tmr = 19'h0;
            nxt_out = '0;
        end else if (eval_ff) begin
            nxt_out.blocked = pick_ff & blk_ff;                        // [RL6]
            unique case (st_ff)
                SVS_IDLE: begin
                    if (pick_ff && !blk_ff) begin
                        nxt_st        = SVS_RUN;                       // [RL5]
                        nxt_out.start = 1'b1;
                        nxt_tmr       = 19'h0;
                        if (instant && trip_ok) begin
                            nxt_st       = SVS_TRIP;                   // [RL11]
                            nxt_out.trip = 1'b1;
                        end
                    end
                end
                SVS_RUN: begin
                    if (blk_ff || !pick_ff) begin
                        nxt_st        = SVS_REL;                       // [RL7] [RL22]
                        nxt_rcnt      = 19'h0;
                        nxt_out.start = ~blk_ff;
                    end else begin
                        nxt_tmr = tmr_inc;                             // [RL23]
                        if (tmr_inc >= expect_t && trip_ok) begin
                            nxt_st       = SVS_TRIP;                   // [RL12] [RL13]
                            nxt_out.trip = 1'b1;
                        end
                    end
                end
                SVS_TRIP: begin
                    if (blk_ff || !pick_ff || !trip_ok) begin
                        nxt_st  = SVS_IDLE;
                        nxt_tmr = 19'h0;
                        nxt_out.start = 1'b0;
                        nxt_out.trip  = 1'b0;
                    end
                end
                SVS_REL: begin
                    nxt_rcnt = rcnt_ff + 19'h1;
                    if (blk_ff) begin
                        nxt_out.start = 1'b0;                          // [RL7]
                    end
                    if (pick_ff && !blk_ff) begin
                        nxt_st        = SVS_RUN;
                        nxt_out.start = 1'b1;
                    end else if (nxt_rcnt >= rel_ff) begin
                        nxt_st        = SVS_IDLE;                      // [RL22]
                        nxt_tmr       = 19'h0;
                        nxt_out.start = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff   <= SVS_IDLE;
            tmr_ff  <= 19'h0;
            rcnt_ff <= 19'h0;
            out_ff  <= '0;
            eval_ff <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            tmr_ff  <= nxt_tmr;
            rcnt_ff <= nxt_rcnt;
            out_ff  <= nxt_out;
            eval_ff <= tick;
        end
    end

    assign stage_out = out_ff;

    // remaining time is signed: negative once the delay is overrun
    always_comb begin
        remain_t = (st_ff == SVS_IDLE) ? 20'h0
                 : 20'(expect_t) - 20'(tmr_ff);                       // [RL17]
    end

    // ----------------------------------------
    // logical node behaviour
    // ----------------------------------------
    always_comb begin
        unique case (ctrl_ff.ln_mode)
            SVS_LN_TEST, SVS_LN_TESTBLK:
                ln_beh = (out_ff.blocked || ctrl_ff.ln_mode == SVS_LN_TESTBLK)
                       ? SVS_LN_TESTBLK : SVS_LN_TEST;                 // [RL20]
            SVS_LN_OFF:
                ln_beh = SVS_LN_OFF;
            default:
                ln_beh = (out_ff.blocked || ctrl_ff.ln_mode == SVS_LN_BLOCKED)
                       ? SVS_LN_BLOCKED : SVS_LN_ON;                   // [RL20]
        endcase
    end

    // ----------------------------------------
    // blocking event capture
    // ----------------------------------------
    svs_evt_s   evt_ff, nxt_evt;
    logic [7:0] nxt_evcnt;
    logic       blk_rise;

    always_comb begin
        blk_rise  = nxt_out.blocked & ~out_ff.blocked;
        nxt_evt   = evt_ff;
        nxt_evcnt = evcnt_ff;
        nxt_evt.blk_evt = blk_rise;                                    // [RL8]
        nxt_evt.hmi_evt = blk_rise;                                    // [RL8]
        if (blk_rise) begin
            nxt_evt.blk_voltage = measured_voltage;                    // [RL8]
            nxt_evt.blk_under   = ctrl_ff.under_mode;
            nxt_evcnt           = evcnt_ff + 8'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_ff   <= '0;
            evcnt_ff <= 8'h0;
        end else begin
            evt_ff   <= nxt_evt;
            evcnt_ff <= nxt_evcnt;
        end
    end

    assign evv_ff    = evt_ff.blk_voltage;
    assign evu_ff    = evt_ff.blk_under;
    assign stage_evt = evt_ff;
endmodule

// ===== core/svs_cfg.svh
// constants of the sequence voltage stage: offsets, release ratios, resets, timing
`ifndef SVS_CFG_SVH
`define SVS_CFG_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SVS_CLK_MHZ        100
`define SVS_PROG_CYCLE_US  5000
`define SVS_TICK_CYC       (`SVS_PROG_CYCLE_US * `SVS_CLK_MHZ)
`define SVS_TIME_MAX_TICKS 19'h57E40
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SVS_OFS_CTRL    8'h00
`define SVS_OFS_USET    8'h04
`define SVS_OFS_UNDER_BLOCK_LEVEL    8'h08
`define SVS_OFS_DELAY   8'h0C
`define SVS_OFS_TDIAL   8'h10
`define SVS_OFS_MULT    8'h14
`define SVS_OFS_RELEASE 8'h18
`define SVS_OFS_VTPRI   8'h1C
`define SVS_OFS_STATUS  8'h20
`define SVS_OFS_EXPECT  8'h24
`define SVS_OFS_REMAIN  8'h28
`define SVS_OFS_RATIO   8'h2C
`define SVS_OFS_PRIM    8'h30
`define SVS_OFS_BLKEVT  8'h34
// ----------------------------------------
// reset values
// ----------------------------------------
`define SVS_RST_CTRL    9'h044
`define SVS_RST_USET    16'h2904
`define SVS_RST_UNDER_BLOCK_LEVEL    16'h01F4
`define SVS_RST_DELAY   19'h00008
`define SVS_RST_TDIAL   16'h0064
`define SVS_RST_MULT    16'h0064
`define SVS_RST_RELEASE 19'h0000C
`define SVS_RST_VTPRI   24'h002710
// ----------------------------------------
// pick-up release ratios in percent
// ----------------------------------------
`define SVS_REL_OVER_PCT  8'h61
`define SVS_REL_UNDER_PCT 8'h67
`define SVS_PCT_FULL      8'h64
`endif

// ===== core/svs_pkg.sv
// types of the sequence voltage stage
package svs_pkg;
    typedef enum logic [1:0] {
        SVS_IDLE = 2'h0,
        SVS_RUN  = 2'h1,
        SVS_TRIP = 2'h3,
        SVS_REL  = 2'h2
    } svs_state_e;

    typedef enum logic [1:0] {
        SVS_DLY_FIXED   = 2'h1,
        SVS_DLY_INVERSE = 2'h2
    } svs_dly_e;

    typedef enum logic [2:0] {
        SVS_LN_ON      = 3'h1,
        SVS_LN_BLOCKED = 3'h2,
        SVS_LN_TEST    = 3'h3,
        SVS_LN_TESTBLK = 3'h4,
        SVS_LN_OFF     = 3'h5
    } svs_ln_e;

    typedef struct packed {
        logic [2:0] ln_mode;
        logic       force_blk;
        logic       force_en;
        logic [1:0] dly_type;
        logic       under_mode;
        logic       spare;
    } svs_ctrl_s;

    typedef struct packed {
        logic start;
        logic trip;
        logic blocked;
    } svs_out_s;

    typedef struct packed {
        logic        blk_evt;
        logic        hmi_evt;
        logic [15:0] blk_voltage;
        logic        blk_under;
    } svs_evt_s;
endpackage

// ===== test/svs_stage_sva.sv
// checker: bus handshake, tick pacing, stage output timing and block events
`timescale 1ns/1ns
module svs_stage_sva
    import svs_pkg::*;
#(
    parameter int TICK_CYC = 20
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // register bus
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // stage side
    input wire svs_out_s    stage_out,
    input wire svs_evt_s    stage_evt,
    input wire logic        cycle_tick
);
    logic [31:0] cnt_ff, nxt_cnt;
    logic        seen_ff, nxt_seen;
    always_comb begin
        nxt_cnt = cycle_tick ? 32'h0 : cnt_ff + 32'h1;
        nxt_seen = seen_ff | cycle_tick;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 32'h0;
            seen_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            seen_ff <= nxt_seen;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("wait state longer than one cycle");
    a_unmap_zero: assert property (read && !waitrequest && address == 8'h3C |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    a_tick_period: assert property (seen_ff && cycle_tick |-> cnt_ff == TICK_CYC - 1)
        else $error("tick spacing wrong");
    a_tick_due: assert property (cnt_ff <= TICK_CYC)
        else $error("tick missing");
    a_out_eval: assert property (!$stable(stage_out) |-> $past(cycle_tick, 2))
        else $error("stage output changed off evaluation");
    a_blk_excl: assert property (stage_out.blocked |-> !stage_out.start && !stage_out.trip)
        else $error("start or trip while blocked");
    a_evt_follow: assert property ($rose(stage_out.blocked) |-> ##[0:1] stage_evt.blk_evt)
        else $error("no block event");
    a_evt_pulse: assert property (stage_evt.blk_evt |=> !stage_evt.blk_evt)
        else $error("block event longer than one cycle");
    a_evt_hmi: assert property (stage_evt.blk_evt |-> stage_evt.hmi_evt)
        else $error("display event missing");
    c_trip: cover property ($rose(stage_out.trip));
    c_block: cover property ($rose(stage_out.blocked));
    c_instant: cover property ($rose(stage_out.start) && stage_out.trip);
endmodule
bind svs_stage svs_stage_sva #(.TICK_CYC(TICK_CYC)) u_sva (.clk, .rstn, .address, .read,
    .write, .readdata, .waitrequest, .stage_out, .stage_evt, .cycle_tick);

// ===== test/svs_relay_model.sv
// blocking source of the relay matrix: follows a request after a set lag
`timescale 1ns/1ns
module svs_relay_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // request
    input  wire logic       blk_req,
    input  wire logic [3:0] lag,
    // blocking line
    output logic            block_in
);
    logic [3:0] cnt_ff, nxt_cnt;
    logic       blk_ff, nxt_blk;
    // lag stays below one processing cycle, so a block lands before the delay ends
    always_comb begin
        nxt_cnt = 4'h0;
        nxt_blk = blk_ff;
        if (blk_req != blk_ff) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff >= lag) begin
                nxt_blk = blk_req;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 4'h0;
            blk_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            blk_ff <= nxt_blk;
        end
    end
    assign block_in = blk_ff;
endmodule

// ===== test/svs_stage_bench.sv
// bench: register map, fixed and instant timing, blocking, forcing, under-block
`timescale 1ns/1ns
module svs_stage_bench;
    import svs_pkg::*;
    localparam logic [7:0] RA [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
        8'h1C, 8'h30, 8'h3C};
    localparam logic [31:0] RV [10] = '{32'h44, 32'h2904, 32'h1F4, 32'h8, 32'h64, 32'h64,
        32'hC, 32'h2710, 32'h19A28, 32'h0};
    logic        clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, blk_req = 1'b0;
    logic [7:0]  address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata, me, mm;
    logic        waitrequest, block_in, cycle_tick;
    logic [15:0] meas = 16'h0, min_line = 16'h0;
    logic [3:0]  lag = 4'h0;
    svs_out_s    stage_out;
    svs_evt_s    stage_evt;
    logic [31:0] q_e[$], q_m[$];
    int          n_mismatch = 0, tests_run = 0, cyc = 0, n, r;
    always #5 clk = ~clk;
    svs_stage #(.TICK_CYC(20)) dut (.clk, .rstn, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .measured_voltage(meas), .min_line_voltage(min_line),
        .block_in, .stage_out, .stage_evt, .cycle_tick);
    svs_relay_model u_relay (.clk, .rstn, .blk_req, .lag, .block_in);
    task results;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        @(posedge clk);
        while (waitrequest) @(posedge clk);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        q_e.push_back(e);
        q_m.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask
    task wfor(input int b, input logic v);
        n = 0;
        while (stage_out[b] !== v && n < 600) begin
            @(posedge clk);
            n++;
        end
        if (n >= 600) chk("wait bound", 32'h0, 32'h1);
    endtask
    task drop(input logic [15:0] v);
        meas <= v;
        wfor(2, 1'b0);
    endtask
    // read results are compared against the oldest note
    always @(posedge clk) begin
        if (read && !waitrequest && q_e.size() > 0) begin
            me = q_e.pop_front();
            mm = q_m.pop_front();
            chk("readdata", readdata & mm, me & mm);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results;
        end
    end
    initial begin
        r = $urandom(45);
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 10; i++) rd(RA[i], RV[i], 32'hFFFFFFFF);
        r = $urandom_range(99, 1);
        lag <= 4'($urandom_range(15, 0));
        meas <= 16'(105 * r);
        repeat (50) @(posedge clk);
        rd(8'h2C, r, 32'hFFFF);
        wr_seq(32'h44, 32'h3);
        meas <= 16'd11000;
        wfor(2, 1'b1);
        rd(8'h28, 32'h3, 32'hFFFFFFFF);
        wfor(1, 1'b1);
        // the remaining-time read above takes three of the sixty cycles
        chk("fixed delay", n, 57);
        rd(8'h24, 32'h3, 32'hFFFFFFFF);
        drop(16'd0);
        wr_seq(32'h44, 32'h0);
        meas <= 16'd11000;
        wfor(2, 1'b1);
        chk("instant trip", stage_out.trip, 1'b1);
        drop(16'd0);
        wr_seq(32'h44, 32'h3);
        meas <= 16'd11000;
        wfor(2, 1'b1);
        blk_req <= 1'b1;
        wfor(0, 1'b1);
        chk("start on block", stage_out.start, 1'b0);
        rd(8'h34, 32'd11000, 32'h1FFFF);
        meas <= 16'd0;
        wfor(0, 1'b0);
        meas <= 16'd11000;
        wfor(0, 1'b1);
        repeat (80) @(posedge clk);
        chk("blocked pick", stage_out, 3'b001);
        blk_req <= 1'b0;
        meas <= 16'd0;
        wfor(0, 1'b0);
        wr_seq(32'h74, 32'h3);
        meas <= 16'd11000;
        wfor(0, 1'b1);
        chk("forced block", stage_out.start, 1'b0);
        meas <= 16'd0;
        wfor(0, 1'b0);
        for (int k = 1; k < 6; k++) begin
            bus(1'b1, 8'h00, 32'(k << 6));
            repeat (40) @(posedge clk);
            rd(8'h20, 32'(k << 4), 32'h70);
        end
        meas <= 16'd300;
        wr_seq(32'h46, 32'h0);
        wfor(2, 1'b1);
        chk("under block trip", stage_out.trip, 1'b0);
        meas <= 16'd3000;
        repeat (60) @(posedge clk);
        chk("under block held", stage_out.trip, 1'b0);
        min_line <= 16'd11000;
        wfor(1, 1'b1);
        chk("under block exit", n < 60, 1'b1);
        min_line <= 16'd0;
        drop(16'd11000);
        meas <= 16'd300;
        wfor(2, 1'b1);
        chk("under block again", stage_out.trip, 1'b0);
        bus(1'b1, 8'h08, 32'h0);
        wfor(1, 1'b1);
        chk("no under block", stage_out.trip, 1'b1);
        meas <= 16'd21000;
        bus(1'b1, 8'h00, 32'h48);
        rd(8'h24, 32'd200, 32'hFFFFFFFF);
        meas <= 16'd15750;
        rd(8'h24, 32'd400, 32'hFFFFFFFF);
        results;
    end
    task wr_seq(input logic [31:0] ctrl, input logic [31:0] dly);
        bus(1'b1, 8'h00, ctrl);
        bus(1'b1, 8'h0C, dly);
    endtask
endmodule
